/* tb/qsg_checker.sv */
// Port checker of the abnormal-status group.
// Assumes a bind to qsg_top from the bench top file.
`timescale 1ns/10ps
`default_nettype none
`include "qsg_consts.svh"
module qsg_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire qsg_pkg::addr_t paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Summary
  input wire logic abnormal_summary_bit,
  input wire logic [7:0] status_byte
);
  import qsg_pkg::*;
  wire logic acc = psel && penable && !pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (acc |=> pready)
    else $error("no answer after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_cond_readonly: assert property (acc && pwrite && paddr == `QSG_OFS_COND |=> pslverr)
    else $error("condition write accepted");
  a_event_readonly: assert property (acc && pwrite && paddr == `QSG_OFS_EVENT |=> pslverr)
    else $error("event write accepted");
  a_summary_byte: assert property (status_byte == {4'h0, abnormal_summary_bit, 3'h0})
    else $error("status byte wrong");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_cond_unused: assert property (pready && paddr == `QSG_OFS_COND |->
    (prdata & ~32'h0000_0613) == 32'h0)
    else $error("unused condition bit set");
  a_read_ok: assert property (acc && !pwrite && paddr == `QSG_OFS_EVENT |=> !pslverr)
    else $error("event read refused");
endmodule
`default_nettype wire

/* tb/qsg_monitor_model.sv */
// Stand-in for the protection and regulation monitors.
// Assumes the bench moves want just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module qsg_monitor_model (
  input wire logic pclk,
  input wire logic [4:0] want,
  output qsg_pkg::abnormal_in_s abnormal_in
);
  import qsg_pkg::*;
  always_ff @(posedge pclk) abnormal_in <= want;
endmodule
`default_nettype wire

/* tb/questionable_status_group_test.sv */
// Self-checking bench of the abnormal-status group.
// Assumes qsg_top, the checker and the monitor model compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "qsg_consts.svh"
module questionable_status_group_test;
  import qsg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  addr_t paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, got;
  logic pready, pslverr, summ, irq;
  logic [7:0] sbyte;
  logic [4:0] want = 5'h00;
  abnormal_in_s ain;
  int miscompares = 0, checks_done = 0, cycles = 0;
  initial forever #50 pclk = ~pclk;
  qsg_monitor_model i_qsg_monitor_model (.pclk(pclk), .want(want), .abnormal_in(ain));
  qsg_top i_qsg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .abnormal_in(ain), .abnormal_summary_bit(summ),
    .status_byte(sbyte), .irq(irq));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // A transfer holds every request signal until pready is seen high.
  task automatic apb(input logic w, input addr_t a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    got = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      $display("unexpected at %0t: no answer from the slave", $time);
      conclude();
    end
  endtask
  task automatic rd(input addr_t a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(got, e);
  endtask
  task automatic wr(input addr_t a, input logic [31:0] d);
    apb(1'b1, a, d);
    cmp({31'h0, err}, 32'h0);
  endtask
  // Five edges cover the model flop, the two sync flops and the latch.
  task automatic drive(input logic [4:0] v);
    @(posedge pclk);
    want <= v;
    repeat (5) @(posedge pclk);
  endtask
  task automatic t_regs;
    addr_t a[3] = '{`QSG_OFS_ENABLE, `QSG_OFS_RISE, `QSG_OFS_FALL};
    rd(`QSG_OFS_EVENT, 32'h0);
    foreach (a[i]) begin
      rd(a[i], 32'h0);
      wr(a[i], 32'h7FD7);
      rd(a[i], 32'h0613);
      wr(a[i], 32'h0);
    end
    // Arming every falling filter while all conditions sit low latches each used bit.
    rd(`QSG_OFS_EVENT, 32'h0613);
    apb(1'b0, 8'h40, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, `QSG_OFS_COND, 32'h1);
    cmp({31'h0, err}, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_cond;
    drive(5'h1F);
    rd(`QSG_OFS_COND, 32'h0613);
    drive(5'h00);
    rd(`QSG_OFS_COND, 32'h0);
    rd(`QSG_OFS_EVENT, 32'h0);
    $display("t_cond done");
  endtask
  task automatic t_edges;
    wr(`QSG_OFS_RISE, 32'h0001);
    wr(`QSG_OFS_FALL, 32'h0002);
    apb(1'b0, `QSG_OFS_EVENT, 32'h0);
    drive(5'h03);
    rd(`QSG_OFS_EVENT, 32'h0001);
    rd(`QSG_OFS_EVENT, 32'h0);
    drive(5'h00);
    rd(`QSG_OFS_EVENT, 32'h0002);
    wr(`QSG_OFS_RISE, 32'h0010);
    wr(`QSG_OFS_FALL, 32'h0010);
    rd(`QSG_OFS_EVENT, 32'h0010);
    drive(5'h04);
    rd(`QSG_OFS_EVENT, 32'h0010);
    drive(5'h00);
    rd(`QSG_OFS_EVENT, 32'h0010);
    drive(5'h10);
    apb(1'b0, `QSG_OFS_EVENT, 32'h0);
    wr(`QSG_OFS_RISE, 32'h0410);
    rd(`QSG_OFS_EVENT, 32'h0400);
    // The rise reaches the event word at the very edge of the clearing read.
    @(posedge pclk);
    want <= 5'h14;
    @(posedge pclk);
    rd(`QSG_OFS_EVENT, 32'h0);
    rd(`QSG_OFS_EVENT, 32'h0010);
    drive(5'h10);
    apb(1'b0, `QSG_OFS_EVENT, 32'h0);
    $display("t_edges done");
  endtask
  task automatic t_summary;
    wr(`QSG_OFS_ENABLE, 32'h0010);
    drive(5'h14);
    cmp({31'h0, summ}, 32'h1);
    cmp({24'h0, sbyte}, 32'h08);
    rd(`QSG_OFS_EVENT, 32'h0010);
    cmp({31'h0, summ}, 32'h0);
    wr(`QSG_OFS_ENABLE, 32'h0);
    drive(5'h10);
    cmp({31'h0, summ}, 32'h0);
    wr(`QSG_OFS_ENABLE, 32'h0010);
    repeat (2) @(posedge pclk);
    cmp({31'h0, summ}, 32'h1);
    apb(1'b0, `QSG_OFS_EVENT, 32'h0);
    $display("t_summary done");
  endtask
  task automatic t_irq;
    wr(`QSG_OFS_IRQ_STAT, 32'h3);
    wr(`QSG_OFS_IRQ_MASK, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    drive(5'h14);
    cmp({31'h0, irq}, 32'h1);
    wr(`QSG_OFS_IRQ_STAT, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    wr(`QSG_OFS_IRQ_MASK, 32'h0);
    drive(5'h10);
    cmp({31'h0, irq}, 32'h0);
    rd(`QSG_OFS_IRQ_STAT, 32'h3);
    wr(`QSG_OFS_IRQ_STAT, 32'h3);
    rd(`QSG_OFS_IRQ_STAT, 32'h0);
    $display("t_irq done");
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cond();
    t_edges();
    t_summary();
    t_irq();
    conclude();
  end
endmodule
bind qsg_top qsg_checker i_qsg_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .abnormal_summary_bit(abnormal_summary_bit),
  .status_byte(status_byte));
`default_nettype wire

/* verilog/qsg_consts.svh */
// Constants of the abnormal-status reporting group: offsets, fields, resets.
// Assumes inclusion by bare name from package and modules; definitions only.
//
// Operation
// RL1 - Enable mask selects events for summary
// RL2 - Summary bit is OR of enabled events
// RL3 - Mask read/write, host limits range, resets zero
// RL4 - Event register read-only, latches filtered transitions
// RL5 - Reading event register returns then clears
// RL6 - Falling filter catches one-to-zero changes
// RL7 - Rising filter catches zero-to-one changes
// RL8 - Both filters set catch any change
// RL9 - Both filters clear catch nothing
// RL10 - Filter write in matching state sets event
// RL11 - Filters read/write, host limits range, reset zero
// RL12 - Condition register shows live inputs
// RL13 - Condition bits 0,1,4,9,10 used, rest zero
// RL14 - New event survives same-cycle clearing read
// RL15 - Reset clears events, captures inputs as reference
`ifndef QSG_CONSTS_SVH
`define QSG_CONSTS_SVH

`define QSG_WIDTH 16
`define QSG_ADDR_W 8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define QSG_OFS_COND 8'h00
`define QSG_OFS_EVENT 8'h04
`define QSG_OFS_ENABLE 8'h08
`define QSG_OFS_RISE 8'h0C
`define QSG_OFS_FALL 8'h10
`define QSG_OFS_IRQ_STAT 8'h14
`define QSG_OFS_IRQ_MASK 8'h18

// ----------------------------------------------------------------------
// Condition bit positions and the mask of implemented bits
// ----------------------------------------------------------------------
`define QSG_BIT_OV 0
`define QSG_BIT_OC 1
`define QSG_BIT_OT 4
`define QSG_BIT_RI 9
`define QSG_BIT_UNR 10
`define QSG_USED_MASK 16'h0613

// ----------------------------------------------------------------------
// Reset values, status byte position, interrupt status bits
// ----------------------------------------------------------------------
`define QSG_RST_ENABLE 16'h0000
`define QSG_RST_FILTER 16'h0000
`define QSG_STB_BIT 3
`define QSG_IRQ_W 2
`define QSG_IRQ_EVENT 0
`define QSG_IRQ_SUMMARY 1

`endif

/* verilog/qsg_edge_filter.sv */
// Per-bit transition filter: turns condition changes into set requests.
// Assumes cond and prev are on pclk; the parent owns the previous-state flop.
`timescale 1ns/10ps
`default_nettype none

module qsg_edge_filter #(
  parameter int WIDTH = 16
) (
  // Condition now and one cycle ago
  input wire logic [WIDTH-1:0] cond,
  input wire logic [WIDTH-1:0] prev,
  // Filters, and filter bits newly turned on by a write
  input wire logic [WIDTH-1:0] rising_edge_filter,
  input wire logic [WIDTH-1:0] falling_edge_filter,
  input wire logic [WIDTH-1:0] rise_armed,
  input wire logic [WIDTH-1:0] fall_armed,
  // Event set requests
  output logic [WIDTH-1:0] set_req
);
  initial begin
    if (WIDTH < 1) $error("qsg_edge_filter: WIDTH must be positive");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      wire rise = cond[i] & ~prev[i];
      wire fall = ~cond[i] & prev[i];
      // Both filters on pass either change; both off pass none.
      wire pass_edge = (rise & rising_edge_filter[i]) // RL7 RL8 RL9
                     | (fall & falling_edge_filter[i]); // RL6
      // Turning a filter on while the level already matches counts as an event.
      wire pass_arm = (rise_armed[i] & cond[i]) | (fall_armed[i] & ~cond[i]); // RL10
      assign set_req[i] = pass_edge | pass_arm;
    end
  endgenerate
endmodule

`default_nettype wire

/* verilog/qsg_pkg.sv */
// Types of the abnormal-status reporting group.
// Assumes qsg_consts.svh on the include path.
`include "qsg_consts.svh"

package qsg_pkg;
  typedef logic [`QSG_WIDTH-1:0] word_t;
  typedef logic [`QSG_ADDR_W-1:0] addr_t;

  // The five monitored protection and regulation signals.
  typedef struct packed {
    logic output_unregulated_flag;
    logic remote_inhibit_flag;
    logic overtemperature_flag;
    logic overcurrent_trip;
    logic overvoltage_trip;
  } abnormal_in_s;

  // APB request as seen by the slave.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    addr_t paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage

/* verilog/qsg_sync.sv */
// Two-flop synchroniser for a vector of asynchronous level inputs.
// Assumes inputs are slow levels; multi-bit skew of one cycle is acceptable.
`timescale 1ns/10ps
`default_nettype none

module qsg_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  initial begin
    if (WIDTH < 1) $error("qsg_sync: WIDTH must be positive");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

`default_nettype wire

/* verilog/qsg_top.sv */
// Abnormal-status reporting group: condition, filters, event, enable mask.
// Assumes an APB master on pclk and asynchronous protection monitor inputs.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "qsg_consts.svh"

module qsg_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire qsg_pkg::addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored conditions, asynchronous levels
  input wire qsg_pkg::abnormal_in_s abnormal_in,
  // Status byte summary and interrupt
  output logic abnormal_summary_bit,
  output logic [7:0] status_byte,
  output logic irq
);
  import qsg_pkg::*;

  // --------------------------------------------------------------------
  // Input synchronisation and condition word
  // --------------------------------------------------------------------
  localparam int NIN = $bits(abnormal_in_s);
  abnormal_in_s sync_in;
  logic [NIN-1:0] sync_vec;
  word_t cond_w;

  qsg_sync #(.WIDTH(NIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(abnormal_in),
    .sync_out(sync_vec)
  );
  assign sync_in = abnormal_in_s'(sync_vec);

  // Unused positions are tied low so every register shows zero there.
  always_comb begin
    cond_w = '0;
    cond_w[`QSG_BIT_OV] = sync_in.overvoltage_trip; // RL13
    cond_w[`QSG_BIT_OC] = sync_in.overcurrent_trip;
    cond_w[`QSG_BIT_OT] = sync_in.overtemperature_flag;
    cond_w[`QSG_BIT_RI] = sync_in.remote_inhibit_flag;
    cond_w[`QSG_BIT_UNR] = sync_in.output_unregulated_flag;
  end

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  word_t prev_ff, nxt_prev;
  logic ref_valid_ff;
  word_t event_ff, nxt_event;
  word_t enable_ff, nxt_enable;
  word_t rise_ff, nxt_rise;
  word_t fall_ff, nxt_fall;
  logic [`QSG_IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [`QSG_IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic summary_ff;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  // The access is taken once; the answer cycle must not repeat a write, clear or read.
  wire access = psel & penable & ~pready;
  wire wr_acc = access & pwrite;
  wire rd_acc = access & ~pwrite;
  wire hit_cond = (paddr == `QSG_OFS_COND);
  wire hit_event = (paddr == `QSG_OFS_EVENT);
  wire hit_enable = (paddr == `QSG_OFS_ENABLE);
  wire hit_rise = (paddr == `QSG_OFS_RISE);
  wire hit_fall = (paddr == `QSG_OFS_FALL);
  wire hit_istat = (paddr == `QSG_OFS_IRQ_STAT);
  wire hit_imask = (paddr == `QSG_OFS_IRQ_MASK);
  wire mapped = hit_cond | hit_event | hit_enable | hit_rise | hit_fall
              | hit_istat | hit_imask;
  // Writes to the read-only condition and event words are refused.
  wire bad_wr = wr_acc & (hit_cond | hit_event);
  wire err = access & (~mapped | bad_wr);
  wire [15:0] wdata16 = pwdata[15:0];
  wire wr_enable = wr_acc & hit_enable;
  wire wr_rise = wr_acc & hit_rise;
  wire wr_fall = wr_acc & hit_fall;
  wire rd_event = rd_acc & hit_event;

  // --------------------------------------------------------------------
  // Filter writes and transition detection
  // --------------------------------------------------------------------
  // Only the implemented positions are stored; the host keeps the range.
  assign nxt_enable = wr_enable ? (wdata16 & `QSG_USED_MASK) : enable_ff; // RL3
  assign nxt_rise = wr_rise ? (wdata16 & `QSG_USED_MASK) : rise_ff; // RL11
  assign nxt_fall = wr_fall ? (wdata16 & `QSG_USED_MASK) : fall_ff; // RL11
  wire [15:0] rise_armed = nxt_rise & ~rise_ff;
  wire [15:0] fall_armed = nxt_fall & ~fall_ff;
  word_t set_req;
  // No edge counts until the first synchronised sample becomes the reference.
  wire [15:0] prev_eff = ref_valid_ff ? prev_ff : cond_w;

  qsg_edge_filter #(.WIDTH(`QSG_WIDTH)) u_filter (
    .cond(cond_w),
    .prev(prev_eff),
    .rising_edge_filter(rise_ff),
    .falling_edge_filter(fall_ff),
    .rise_armed(rise_armed),
    .fall_armed(fall_armed),
    .set_req(set_req)
  );

  assign nxt_prev = cond_w; // RL12
  // A read clears the word but a same-cycle event still lands.
  assign nxt_event = (rd_event ? '0 : event_ff) | set_req; // RL4 RL5 RL14

  // --------------------------------------------------------------------
  // Summary and interrupt
  // --------------------------------------------------------------------
  wire nxt_summary = |(nxt_event & nxt_enable); // RL1 RL2
  wire [`QSG_IRQ_W-1:0] irq_evt = {nxt_summary & ~summary_ff, |set_req};
  wire [`QSG_IRQ_W-1:0] irq_clr = (wr_acc & hit_istat) ? pwdata[`QSG_IRQ_W-1:0] : '0;
  // Hardware set wins over a write-one-to-clear in the same cycle.
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;
  assign nxt_irq_mask = (wr_acc & hit_imask) ? pwdata[`QSG_IRQ_W-1:0] : irq_mask_ff;
  wire nxt_irq = |(nxt_irq_stat & nxt_irq_mask);

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // The event word is returned before the clear, since both use one edge.
  wire [15:0] rd16 = hit_cond ? cond_w :
                     hit_event ? event_ff :
                     hit_enable ? enable_ff :
                     hit_rise ? rise_ff :
                     hit_fall ? fall_ff :
                     hit_istat ? {14'h0000, irq_stat_ff} :
                     hit_imask ? {14'h0000, irq_mask_ff} : 16'h0000;
  wire [31:0] nxt_prdata = (rd_acc & mapped) ? {16'h0000, rd16} : 32'h0000_0000;

  // --------------------------------------------------------------------
  // Flip-flops
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_ff <= '0; // RL15
      enable_ff <= `QSG_RST_ENABLE;
      rise_ff <= `QSG_RST_FILTER;
      fall_ff <= `QSG_RST_FILTER;
      prev_ff <= '0;
      ref_valid_ff <= 1'b0;
    end else begin
      event_ff <= nxt_event;
      enable_ff <= nxt_enable;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
      prev_ff <= nxt_prev; // RL15
      ref_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      summary_ff <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      summary_ff <= nxt_summary;
      irq <= nxt_irq;
    end
  end

  // Single-wait-state slave: the answer comes one cycle after the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= nxt_prdata;
      pready <= access & ~pready;
      pslverr <= err & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abnormal_summary_bit <= 1'b0;
      status_byte <= 8'h00;
    end else begin
      abnormal_summary_bit <= nxt_summary; // RL2
      status_byte <= {4'h0, nxt_summary, 3'h0};
    end
  end
endmodule

`default_nettype wire
